// *** rtl/cbt_pkg.sv ***
// Shared constants for the self-test and cache test port
package cbt_pkg;
    // Self test length and warm reset hold, in processor clocks
    localparam int unsigned BUILTIN_SELF_CHECK_CLOCKS = 2 ** 20;
    localparam logic [3:0] RST_HOLD_CLKS = 4'hf;
    // Result left in the accumulator when a flaw is found
    localparam logic [31:0] BUILTIN_SELF_CHECK_FAIL_CODE = 32'h0000_0001;
    localparam logic [31:0] BUILTIN_SELF_CHECK_PAT0 = 32'h5555_5555;
    localparam logic [31:0] BUILTIN_SELF_CHECK_PAT1 = 32'haaaa_aaaa;
    // Test register select on the link
    localparam logic [1:0] TR_DATA = 2'h0;
    localparam logic [1:0] TR_STAT = 2'h1;
    localparam logic [1:0] TR_CMD = 2'h2;
    // Tag/status fields
    localparam int TS_TAG_LSB = 11;
    localparam int TS_VALID_BIT = 10;
    localparam int TS_LRU_LSB = 7;
    localparam int TS_SETV_LSB = 3;
    // Command fields
    localparam int CMD_CTL_LSB = 0;
    localparam int CMD_ENT_LSB = 2;
    localparam int CMD_SET_LSB = 4;
    typedef enum logic [1:0] {
        OP_BUF = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ = 2'b10,
        OP_FLUSH = 2'b11
    } cbt_op_type;
    // Controller register map (byte offsets)
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_RESULT = 5'h08;
    localparam logic [4:0] OFS_TR_DATA = 5'h10;
    localparam logic [4:0] OFS_TR_STAT = 5'h14;
    localparam logic [4:0] OFS_TR_CMD = 5'h18;
    // Control register bits
    localparam int CTRL_START = 0;
    localparam int CTRL_SELFTEST = 1;
    localparam int CTRL_CD = 2;
    localparam int CTRL_NW = 3;
endpackage : cbt_pkg

// *** rtl/cbt_link_if.sv ***
// Link between the processor test logic and its reset and test controller
`timescale 1ns/1ps
`default_nettype none
interface cbt_link_if;
    logic cpu_rst;
    logic address_hold_in;
    logic flush_in_n;
    logic addr_wrap_mask_in_n;
    logic cache_disable_bit;
    logic no_write_through_bit;
    logic tr_wr;
    logic tr_rd;
    logic [1:0] tr_sel;
    logic [31:0] tr_wdata;
    logic [31:0] tr_rdata;
    logic tr_ack;
    logic self_check_done;
    logic [31:0] self_check_result;

    modport dev (
        input cpu_rst, address_hold_in, flush_in_n, addr_wrap_mask_in_n,
        input cache_disable_bit, no_write_through_bit,
        input tr_wr, tr_rd, tr_sel, tr_wdata,
        output tr_rdata, tr_ack, self_check_done, self_check_result
    );
    modport ctl (
        output cpu_rst, address_hold_in, flush_in_n, addr_wrap_mask_in_n,
        output cache_disable_bit, no_write_through_bit,
        output tr_wr, tr_rd, tr_sel, tr_wdata,
        input tr_rdata, tr_ack, self_check_done, self_check_result
    );
endinterface : cbt_link_if
`default_nettype wire

// *** rtl/cbt_device.sv ***
// Processor self test and cache test register logic
// Operation
// (RULE1) Self test needs address hold before reset falls
// (RULE2) Flush low before reset falls, high during test
// (RULE3) Wrap mask held high across reset fall
// (RULE4) Test lasts 2**20 clocks, no bus cycles
// (RULE5) Warm reset held at least fifteen clocks
// (RULE6) Accumulator zero on pass, nonzero on flaw
// (RULE7) Internal reset then normal run after test
// (RULE8) Cache test writes, reads, compares every entry
// (RULE9) Line-wide fill and read buffers
// (RULE10) Buffers move four words through data register
// (RULE11) Cache read returns tag, valid, LRU, set valids
// (RULE12) Seven-bit set select picks the set
// (RULE13) Entry select picks word or way
// (RULE14) Two-bit control code selects operation
// (RULE15) Data write in buffer mode fills word
// (RULE16) Software loads tag and valid before write
// (RULE17) Cache write copies fill buffer, updates LRU
// (RULE18) Data read in buffer mode returns read word
// (RULE19) Software disables cache before test operations
// (RULE20) Test registers reached only by dedicated port
// (RULE21) Cache read fills read buffer and status
// (RULE22) Flush clears LRU and valid only
// (RULE23) Memory accesses blocked during test sequences
//
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
module cbt_device #(
    parameter int unsigned BUILTIN_SELF_CHECK_CLOCKS = cbt_pkg::BUILTIN_SELF_CHECK_CLOCKS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Link to reset and test controller
    cbt_link_if.dev link,
    // Ordinary memory access request from the core
    input wire logic mem_req,
    output logic mem_gnt,
    output logic running
);
    typedef enum logic [2:0] {
        ST_HELD = 3'b000,
        ST_WRITE = 3'b001,
        ST_READ = 3'b010,
        ST_WAIT = 3'b011,
        ST_INTRST = 3'b100,
        ST_RUN = 3'b101
    } cbt_state_type;

    localparam logic [20:0] BUILTIN_SELF_CHECK_LAST = 21'(BUILTIN_SELF_CHECK_CLOCKS - 1);

    // Cache arrays: 128 sets of 4 ways
    logic [127:0] data_mem [0:511];
    logic [20:0] tag_mem [0:511];
    logic [511:0] valid_q;
    logic [127:0][2:0] lru_q;

    cbt_state_type state_q, state_d;
    logic rst_prev_q, hold_prev_q, flush_prev_n_q, wrap_prev_n_q;
    logic pat_q, pat_d;
    logic [8:0] idx_q, idx_d;
    logic [20:0] cyc_q, cyc_d;
    logic fail_q, fail_d;
    logic [31:0] acc_q, acc_d;
    logic [127:0] fill_q, fill_d, rbuf_q, rbuf_d;
    logic [31:0] data_q, data_d, stat_q, stat_d, cmd_q, cmd_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q;

    // Array write controls
    logic arr_we, lru_we, flush_all;
    logic [8:0] arr_idx;
    logic [127:0] arr_data;
    logic [20:0] arr_tag;
    logic arr_valid;
    logic [2:0] lru_val;

    logic [31:0] pat_word;
    logic [1:0] cmd_op, cur_op, w_ent;
    logic [8:0] w_idx;

    // Pseudo-LRU: mark the accessed way as most recent
    function automatic logic [2:0] lru_next(input logic [2:0] l, input logic [1:0] w);
        logic [2:0] n;
        n = l;
        n[0] = w[1];
        if (w[1])
        begin
            n[2] = w[0];
        end
        else
        begin
            n[1] = w[0];
        end
        return n;
    endfunction : lru_next

    assign pat_word = pat_q ? cbt_pkg::BUILTIN_SELF_CHECK_PAT1 : cbt_pkg::BUILTIN_SELF_CHECK_PAT0;
    assign cur_op = cmd_q[cbt_pkg::CMD_CTL_LSB +: 2];
    assign cmd_op = link.tr_wdata[cbt_pkg::CMD_CTL_LSB +: 2];
    assign w_ent = link.tr_wdata[cbt_pkg::CMD_ENT_LSB +: 2];
    assign w_idx = {link.tr_wdata[cbt_pkg::CMD_SET_LSB +: 7], w_ent}; // RULE12 RULE13

    always_comb
    begin
        state_d = state_q;
        pat_d = pat_q;
        idx_d = idx_q;
        cyc_d = cyc_q + 21'h1;
        fail_d = fail_q;
        acc_d = acc_q;
        fill_d = fill_q;
        rbuf_d = rbuf_q;
        data_d = data_q;
        stat_d = stat_q;
        cmd_d = cmd_q;
        rdata_d = rdata_q;
        arr_we = 1'b0;
        lru_we = 1'b0;
        flush_all = 1'b0;
        arr_idx = idx_q;
        arr_data = {4{pat_word}};
        arr_tag = pat_word[20:0];
        arr_valid = 1'b0;
        lru_val = lru_q[idx_q[8:2]];
        case (state_q)
            ST_HELD:
            begin
                cyc_d = 21'h0;
                idx_d = 9'h0;
                pat_d = 1'b0;
                fail_d = 1'b0;
                // Pins are sampled in the clock before reset falls
                if (rst_prev_q && !link.cpu_rst)
                begin
                    if (hold_prev_q && !flush_prev_n_q && wrap_prev_n_q) // RULE1 RULE2 RULE3
                    begin
                        state_d = ST_WRITE;
                    end
                    else
                    begin
                        state_d = ST_RUN;
                    end
                end
            end
            ST_WRITE:
            begin
                arr_we = 1'b1; // RULE8
                idx_d = idx_q + 9'h1;
                if (idx_q == 9'h1ff)
                begin
                    state_d = ST_READ;
                end
            end
            ST_READ:
            begin
                if (data_mem[idx_q] != {4{pat_word}} || tag_mem[idx_q] != pat_word[20:0]) // RULE8
                begin
                    fail_d = 1'b1;
                end
                idx_d = idx_q + 9'h1;
                if (idx_q == 9'h1ff)
                begin
                    pat_d = 1'b1;
                    state_d = pat_q ? ST_WAIT : ST_WRITE;
                end
            end
            ST_WAIT:
            begin
                if (cyc_q >= BUILTIN_SELF_CHECK_LAST) // RULE4
                begin
                    state_d = ST_INTRST;
                end
            end
            ST_INTRST:
            begin
                // Leave no test pattern visible as valid lines
                flush_all = 1'b1; // RULE7
                fill_d = 128'h0;
                rbuf_d = 128'h0;
                data_d = 32'h0;
                stat_d = 32'h0;
                cmd_d = 32'h0;
                acc_d = fail_q ? cbt_pkg::BUILTIN_SELF_CHECK_FAIL_CODE : 32'h0; // RULE6
                state_d = ST_RUN; // RULE7
            end
            ST_RUN:
            begin
                cyc_d = cyc_q;
                if (link.tr_wr) // RULE20
                begin
                    case (link.tr_sel)
                        cbt_pkg::TR_DATA:
                        begin
                            data_d = link.tr_wdata;
                            if (cur_op == cbt_pkg::OP_BUF)
                            begin
                                fill_d[{cmd_q[cbt_pkg::CMD_ENT_LSB +: 2], 5'h0} +: 32] =
                                    link.tr_wdata; // RULE9 RULE10 RULE15
                            end
                        end
                        cbt_pkg::TR_STAT:
                        begin
                            stat_d = link.tr_wdata;
                        end
                        cbt_pkg::TR_CMD:
                        begin
                            cmd_d = link.tr_wdata;
                            arr_idx = w_idx;
                            lru_val = lru_next(lru_q[w_idx[8:2]], w_ent);
                            case (cmd_op) // RULE14
                                cbt_pkg::OP_WRITE:
                                begin
                                    arr_we = 1'b1; // RULE16 RULE17
                                    lru_we = 1'b1;
                                    arr_data = fill_q;
                                    arr_tag = stat_q[cbt_pkg::TS_TAG_LSB +: 21];
                                    arr_valid = stat_q[cbt_pkg::TS_VALID_BIT];
                                end
                                cbt_pkg::OP_READ:
                                begin
                                    rbuf_d = data_mem[w_idx]; // RULE21
                                    stat_d = {tag_mem[w_idx], valid_q[w_idx], lru_q[w_idx[8:2]],
                                        valid_q[{w_idx[8:2], 2'b00} +: 4], 3'h0}; // RULE11
                                end
                                cbt_pkg::OP_FLUSH:
                                begin
                                    flush_all = 1'b1; // RULE22
                                end
                                default:
                                begin
                                end
                            endcase
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            default:
            begin
                state_d = ST_HELD;
            end
        endcase
        case (link.tr_sel)
            cbt_pkg::TR_DATA:
            begin
                rdata_d = (cur_op == cbt_pkg::OP_BUF) ?
                    rbuf_q[{cmd_q[cbt_pkg::CMD_ENT_LSB +: 2], 5'h0} +: 32] : data_q; // RULE18
            end
            cbt_pkg::TR_STAT:
            begin
                rdata_d = stat_q;
            end
            cbt_pkg::TR_CMD:
            begin
                rdata_d = cmd_q;
            end
            default:
            begin
                rdata_d = 32'h0;
            end
        endcase
        if (link.cpu_rst)
        begin
            state_d = ST_HELD;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_q <= ST_HELD;
            rst_prev_q <= 1'b1;
            hold_prev_q <= 1'b0;
            flush_prev_n_q <= 1'b1;
            wrap_prev_n_q <= 1'b0;
            pat_q <= 1'b0;
            idx_q <= 9'h0;
            cyc_q <= 21'h0;
            fail_q <= 1'b0;
            acc_q <= 32'h0;
            fill_q <= 128'h0;
            rbuf_q <= 128'h0;
            data_q <= 32'h0;
            stat_q <= 32'h0;
            cmd_q <= 32'h0;
            rdata_q <= 32'h0;
            ack_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rst_prev_q <= link.cpu_rst;
            hold_prev_q <= link.address_hold_in;
            flush_prev_n_q <= link.flush_in_n;
            wrap_prev_n_q <= link.addr_wrap_mask_in_n;
            pat_q <= pat_d;
            idx_q <= idx_d;
            cyc_q <= cyc_d;
            fail_q <= fail_d;
            acc_q <= acc_d;
            fill_q <= fill_d;
            rbuf_q <= rbuf_d;
            data_q <= data_d;
            stat_q <= stat_d;
            cmd_q <= cmd_d;
            rdata_q <= (link.tr_rd || link.tr_wr) ? rdata_d : rdata_q;
            ack_q <= link.tr_rd || link.tr_wr;
        end
    end

    // Arrays carry no reset; only valid and LRU are cleared
    always_ff @(posedge clock)
    begin
        if (arr_we)
        begin
            data_mem[arr_idx] <= arr_data;
            tag_mem[arr_idx] <= arr_tag;
            valid_q[arr_idx] <= arr_valid;
        end
        if (lru_we)
        begin
            lru_q[arr_idx[8:2]] <= lru_val; // RULE17
        end
        if (flush_all || sys_rst)
        begin
            valid_q <= '0;
            lru_q <= '0;
        end
    end

    assign link.tr_ack = ack_q;
    assign link.tr_rdata = rdata_q;
    assign link.self_check_done = (state_q == ST_RUN);
    assign link.self_check_result = acc_q;
    assign running = (state_q == ST_RUN);
    // Testability reuses the buffers, so core traffic waits while the cache is in test mode
    assign mem_gnt = mem_req && (state_q == ST_RUN)
        && !(link.cache_disable_bit && link.no_write_through_bit); // RULE4 RULE23
endmodule : cbt_device
`default_nettype wire

// *** rtl/cbt_controller.sv ***
// Reset sequencer and test register bridge driving the processor test logic
`timescale 1ns/1ps
`default_nettype none
module cbt_controller (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Link to the processor
    cbt_link_if.ctl link
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_RESET = 2'b01,
        H_TEST = 2'b10
    } cbt_hstate_type;

    cbt_hstate_type state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic builtin_self_check_q, builtin_self_check_d;
    logic [3:0] ctrl_q, ctrl_d;
    logic ack_q, ack_d, issued_q, issued_d;
    logic [31:0] rdata_q, rdata_d;
    logic req, tr_hit, done_wr;

    assign req = avs_read || avs_write;
    assign tr_hit = avs_address[4] && (avs_address[3:2] != 2'b11);
    assign done_wr = avs_write && ack_q;
    assign avs_waitrequest = req && !ack_q;
    assign avs_readdata = rdata_q;

    // Test registers reached only over the dedicated port
    assign link.tr_wr = avs_write && tr_hit && !issued_q && !ack_q; // RULE20
    assign link.tr_rd = avs_read && tr_hit && !issued_q && !ack_q;
    assign link.tr_sel = avs_address[3:2]; // RULE10
    assign link.tr_wdata = avs_writedata; // RULE16
    assign link.cpu_rst = (state_q == H_RESET);
    assign link.address_hold_in = (state_q == H_RESET) && builtin_self_check_q; // RULE1
    assign link.flush_in_n = !((state_q == H_RESET) && builtin_self_check_q); // RULE2
    assign link.addr_wrap_mask_in_n = 1'b1; // RULE3
    assign link.cache_disable_bit = ctrl_q[cbt_pkg::CTRL_CD]; // RULE19
    assign link.no_write_through_bit = ctrl_q[cbt_pkg::CTRL_NW]; // RULE19

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        builtin_self_check_d = builtin_self_check_q;
        ctrl_d = ctrl_q;
        ack_d = 1'b0;
        issued_d = issued_q;
        rdata_d = rdata_q;
        case (state_q)
            H_RESET:
            begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == cbt_pkg::RST_HOLD_CLKS - 4'h1) // RULE5
                begin
                    state_d = builtin_self_check_q ? H_TEST : H_IDLE;
                end
            end
            H_TEST:
            begin
                if (link.self_check_done)
                begin
                    state_d = H_IDLE;
                end
            end
            H_IDLE:
            begin
            end
            default:
            begin
                state_d = H_IDLE;
            end
        endcase
        if (req && !ack_q)
        begin
            if (tr_hit)
            begin
                issued_d = 1'b1;
                if (link.tr_ack)
                begin
                    ack_d = 1'b1;
                    issued_d = 1'b0;
                    rdata_d = link.tr_rdata;
                end
            end
            else
            begin
                ack_d = 1'b1;
                case (avs_address)
                    cbt_pkg::OFS_CTRL: rdata_d = {28'h0, ctrl_q};
                    cbt_pkg::OFS_STATUS: rdata_d = {28'h0, link.self_check_done,
                        state_q == H_TEST, link.cpu_rst, 1'b0};
                    cbt_pkg::OFS_RESULT: rdata_d = link.self_check_result;
                    default: rdata_d = 32'h0;
                endcase
            end
        end
        if (done_wr && avs_address == cbt_pkg::OFS_CTRL)
        begin
            ctrl_d = {avs_writedata[cbt_pkg::CTRL_NW], avs_writedata[cbt_pkg::CTRL_CD], 2'b00};
            if (avs_writedata[cbt_pkg::CTRL_START])
            begin
                state_d = H_RESET;
                cnt_d = 4'h0;
                builtin_self_check_d = avs_writedata[cbt_pkg::CTRL_SELFTEST];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_q <= H_RESET;
            cnt_q <= 4'h0;
            builtin_self_check_q <= 1'b0;
            ctrl_q <= 4'h0;
            ack_q <= 1'b0;
            issued_q <= 1'b0;
            rdata_q <= 32'h0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            builtin_self_check_q <= builtin_self_check_d;
            ctrl_q <= ctrl_d;
            ack_q <= ack_d;
            issued_q <= issued_d;
            rdata_q <= rdata_d;
        end
    end
endmodule : cbt_controller
`default_nettype wire

// *** testbench/cbt_link_props.sv ***
// Assertions on the link between the test controller and the processor test logic
`timescale 1ns/1ps
`default_nettype none
module cbt_link_props #(
    parameter int unsigned BUILTIN_SELF_CHECK_CLOCKS = cbt_pkg::BUILTIN_SELF_CHECK_CLOCKS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Link signals
    input wire logic cpu_rst,
    input wire logic address_hold_in,
    input wire logic flush_in_n,
    input wire logic addr_wrap_mask_in_n,
    input wire logic tr_wr,
    input wire logic tr_rd,
    input wire logic tr_ack,
    input wire logic self_check_done,
    input wire logic [31:0] self_check_result
);
    logic rst_q, rst_d, hold_q, hold_d, tst_q, tst_d;
    logic [4:0] run_q, run_d;
    logic [31:0] cnt_q, cnt_d;
    // Held-reset length saturates so a long reset cannot wrap back below the minimum
    always_comb
    begin
        rst_d = cpu_rst;
        hold_d = address_hold_in;
        run_d = cpu_rst ? ((run_q == 5'h1f) ? run_q : run_q + 5'h01) : 5'h00;
        tst_d = cpu_rst ? 1'b0 : (rst_q ? hold_q : tst_q);
        cnt_d = cpu_rst ? 32'h0 : cnt_q + {31'h0, tst_q & ~self_check_done};
    end
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rst_q <= 1'b0;
            hold_q <= 1'b0;
            tst_q <= 1'b0;
            run_q <= 5'h00;
            cnt_q <= 32'h0;
        end
        else
        begin
            rst_q <= rst_d;
            hold_q <= hold_d;
            tst_q <= tst_d;
            run_q <= run_d;
            cnt_q <= cnt_d;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    ack_cause_a: assert property (tr_ack |-> $past(tr_wr) || $past(tr_rd)) else $error("ack without request");
    ack_follow_a: assert property ((tr_wr || tr_rd) |=> tr_ack) else $error("request not acked");
    ack_pulse_a: assert property (tr_ack |=> !tr_ack) else $error("ack longer than one cycle");
    wrap_high_a: assert property (addr_wrap_mask_in_n) else $error("wrap mask low");
    hold_in_reset_a: assert property (address_hold_in |-> cpu_rst) else $error("hold outside reset");
    flush_request_a: assert property ($fell(cpu_rst) && $past(address_hold_in) |-> !$past(flush_in_n))
        else $error("flush not low before reset fall");
    flush_during_test_a: assert property (tst_q && !self_check_done |-> flush_in_n)
        else $error("flush low during self test");
    reset_length_a: assert property ($fell(cpu_rst) |-> run_q >= 5'h0f) else $error("reset too short");
    held_idle_a: assert property (cpu_rst && $past(cpu_rst) |-> !self_check_done)
        else $error("running while held");
    test_bound_a: assert property (tst_q && !self_check_done |-> cnt_q <= BUILTIN_SELF_CHECK_CLOCKS + 4)
        else $error("self test too long");
    test_length_a: assert property ($rose(self_check_done) && tst_q |-> cnt_q + 4 >= BUILTIN_SELF_CHECK_CLOCKS)
        else $error("self test too short");
    pass_zero_a: assert property ($rose(self_check_done) |-> self_check_result == 32'h0)
        else $error("result nonzero");
    normal_run_a: assert property ($fell(cpu_rst) && !$past(address_hold_in) |-> ##[0:3] self_check_done)
        else $error("no run after plain reset");
    cover property ($rose(self_check_done) && tst_q);
    cover property ($fell(cpu_rst) && !$past(address_hold_in));
    cover property (tr_rd && tr_ack == 1'b0);
endmodule : cbt_link_props
`default_nettype wire

// *** testbench/cpu_builtin_self_check_and_cache_test_port_tb.sv ***
// Testbench joining controller and processor test logic, driven over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module cpu_builtin_self_check_and_cache_test_port_tb;
    localparam int unsigned BCLK = 4096;
    localparam int LIMIT = 30000;
    logic clock, sys_rst, mem_req, avs_read, avs_write, avs_waitrequest, mem_gnt, running;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [2:0] lru;
    int errors, cmp_count, cyc;
    cbt_link_if lnk ();
    cbt_device #(.BUILTIN_SELF_CHECK_CLOCKS(BCLK)) cbt_device_inst (.clock(clock), .sys_rst(sys_rst),
        .link(lnk), .mem_req(mem_req), .mem_gnt(mem_gnt), .running(running));
    cbt_controller cbt_controller_inst (.clock(clock), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link(lnk));
    cbt_link_props #(.BUILTIN_SELF_CHECK_CLOCKS(BCLK)) cbt_link_props_inst (.clock(clock), .sys_rst(sys_rst),
        .cpu_rst(lnk.cpu_rst), .address_hold_in(lnk.address_hold_in),
        .flush_in_n(lnk.flush_in_n), .addr_wrap_mask_in_n(lnk.addr_wrap_mask_in_n),
        .tr_wr(lnk.tr_wr), .tr_rd(lnk.tr_rd), .tr_ack(lnk.tr_ack),
        .self_check_done(lnk.self_check_done), .self_check_result(lnk.self_check_result));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Request held until waitrequest is seen low; an idle cycle follows so strobes never rise twice
    task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : acc
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdc
    function automatic logic [31:0] pat(input int w);
        return 32'hc3a5_0f00 | 32'(w);
    endfunction : pat
    function automatic logic [31:0] cmd(input int set, input int way, input cbt_pkg::cbt_op_type op);
        return (32'(set) << 4) | (32'(way) << 2) | {30'h0, op};
    endfunction : cmd
    initial
    begin
        sys_rst = 1'b1;
        mem_req = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        errors = 0;
        cmp_count = 0;
        cyc = 0;
        lru = 3'h0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        while (running !== 1'b1) @(posedge clock);
        mem_req <= 1'b1;
        @(posedge clock);
        @(posedge clock);
        check({31'h0, mem_gnt}, 32'h1);
        wr(cbt_pkg::OFS_CTRL, 32'hc);
        check({31'h0, mem_gnt}, 32'h0);
        wr(cbt_pkg::OFS_TR_CMD, cmd(0, 0, cbt_pkg::OP_FLUSH));
        for (int w = 0; w < 4; w++)
        begin
            wr(cbt_pkg::OFS_TR_CMD, cmd(0, w, cbt_pkg::OP_BUF));
            wr(cbt_pkg::OFS_TR_DATA, pat(w));
        end
        for (int way = 3; way > 0; way -= 2)
        begin
            wr(cbt_pkg::OFS_TR_STAT, {21'h1f_ff0 | 21'(way), 1'b1, 10'h0});
            wr(cbt_pkg::OFS_TR_CMD, cmd(127, way, cbt_pkg::OP_WRITE));
            lru[0] = way[1];
            if (way[1])
                lru[2] = way[0];
            else
                lru[1] = way[0];
        end
        wr(cbt_pkg::OFS_TR_CMD, cmd(127, 1, cbt_pkg::OP_READ));
        rdc(cbt_pkg::OFS_TR_STAT, {21'h1f_ff1, 1'b1, lru, 4'b1010, 3'h0});
        for (int w = 0; w < 4; w++)
        begin
            wr(cbt_pkg::OFS_TR_CMD, cmd(0, w, cbt_pkg::OP_BUF));
            rdc(cbt_pkg::OFS_TR_DATA, pat(w));
        end
        wr(cbt_pkg::OFS_TR_CMD, cmd(0, 0, cbt_pkg::OP_FLUSH));
        wr(cbt_pkg::OFS_TR_CMD, cmd(127, 3, cbt_pkg::OP_READ));
        rdc(cbt_pkg::OFS_TR_STAT, {21'h1f_ff3, 11'h0});
        wr(cbt_pkg::OFS_TR_CMD, cmd(0, 2, cbt_pkg::OP_BUF));
        rdc(cbt_pkg::OFS_TR_DATA, pat(2));
        wr(cbt_pkg::OFS_CTRL, 32'h3);
        while (lnk.cpu_rst !== 1'b1) @(posedge clock);
        // Done still shows the old run until the held state registers
        while (lnk.self_check_done !== 1'b0) @(posedge clock);
        while (lnk.self_check_done !== 1'b1)
        begin
            check({31'h0, mem_gnt}, 32'h0);
            @(posedge clock);
        end
        @(posedge clock);
        rdc(cbt_pkg::OFS_RESULT, 32'h0);
        rdc(cbt_pkg::OFS_STATUS, 32'h8);
        check({30'h0, running, mem_gnt}, 32'h3);
        rdc(cbt_pkg::OFS_TR_STAT, 32'h0);
        wr(5'h1c, 32'hffff_ffff);
        rdc(5'h1c, 32'h0);
        rdc(5'h0c, 32'h0);
        finish_test();
    end
endmodule : cpu_builtin_self_check_and_cache_test_port_tb
`default_nettype wire
